/* shared/upl_pkg.sv */
// Overview of operation
// - parity bit placed in msb when enabled
// - parity type zero even, one odd
// - loop clear uses pin; source zero loopback_select
// - loop and source set: single wire
// - edge flag on polarity selected edge
// - edge flag cleared by writing one
// - mismatch flag when sample differs from sent
// - mismatch flag cleared by writing one
// - record sampled level on mismatch
// - break flag when enabled break received
// - each flag interrupts only when enabled
// - infrared enable turns modulator on
// - narrow pulse code is stored and read back only, no pulse width logic uses it
// - mismatch mode off, tick 9, tick 13
// - break detector enable bit
// - alternate map only when select bit set
// - normal map visible when select clear
package upl_pkg;
  localparam int ADDR_W = 12;
  // register indices, byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_ALT_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] IDX_ALT_IRQ_EN = 12'h001;
  localparam logic [ADDR_W-1:0] IDX_ALT_IR_CTRL = 12'h002;
  localparam logic [ADDR_W-1:0] IDX_FRAME_CTRL = 12'h002;
  localparam logic [ADDR_W-1:0] IDX_MAP_CTRL = 12'h010;
  localparam logic [ADDR_W-1:0] IDX_TX_CTRL = 12'h011;
  localparam logic [ADDR_W-1:0] IDX_LINE_STAT = 12'h012;
  // alt status / irq enable fields
  localparam int B_EDGE = 7;
  localparam int B_MISV = 2;
  localparam int B_MIS = 1;
  localparam int B_BRK = 0;
  // infrared / error control fields
  localparam int B_IR = 7;
  localparam int B_NP_LO = 5;
  localparam int B_MM_LO = 1;
  localparam int B_BKON = 0;
  // frame control fields
  localparam int B_LOOP = 7;
  localparam int B_SRC = 5;
  localparam int B_PAR = 1;
  localparam int B_ODD = 0;
  // map and tx control fields
  localparam int B_MAP = 0;
  localparam int B_POL = 1;
  localparam int B_TXGO = 0;
  localparam logic [1:0] MM_OFF = 2'h0;
  localparam logic [1:0] MM_T9 = 2'h1;
  localparam logic [1:0] MM_T13 = 2'h2;
  localparam logic [3:0] TICK_9 = 4'h8;
  localparam logic [3:0] TICK_13 = 4'hc;
  localparam int TICKS_PER_BIT = 16;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int BRK_BITS = 10;
  localparam logic [15:0] DIV_RST = 16'h0008;
endpackage

/* hdl/upl_core.sv */
`timescale 1ns/1ps
module upl_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [upl_pkg::ADDR_W+1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_pin_oe,
  output logic ir_on,
  output logic irq
);
  import upl_pkg::*;

  typedef enum logic [1:0] {
    UPL_IDLE = 2'b00,
    UPL_START = 2'b01,
    UPL_DATA = 2'b10,
    UPL_STOP = 2'b11
  } upl_tx_e;

  logic [7:0] alt_stat_reg, alt_stat_next;
  logic [7:0] alt_ien_reg, alt_ien_next;
  logic [7:0] alt_ir_reg, alt_ir_next;
  logic [7:0] frame_reg, frame_next;
  logic map_reg, map_next;
  logic pol_reg, pol_next;
  logic [7:0] txd_reg, txd_next;
  logic txgo_reg, txgo_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [2:0] rx_sync_reg;
  logic rx_prev_reg, rx_prev_next;
  logic [15:0] div_reg, div_next;
  logic [3:0] tick_reg, tick_next;
  logic [3:0] bitn_reg, bitn_next;
  upl_tx_e st_reg, st_next;
  logic [8:0] sh_reg, sh_next;
  logic txo_reg, txo_next;
  logic oe_reg, oe_next;
  logic irq_reg, irq_next;
  logic ir_reg;
  logic [7:0] low_cnt_reg, low_cnt_next;
  logic brk_armed_reg, brk_armed_next;

  logic rx_pin_clean, rx_in, tick_en, sample_en, edge_ev, mis_ev, brk_ev;
  logic acc, wr, rd, hit;
  logic [ADDR_W-1:0] idx;
  logic [3:0] nbits;
  logic par_bit;

  // pin input: three flops, change accepted when the last two agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_sync_reg <= 3'h7;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
    end
  end

  always_comb begin
    rx_pin_clean = rx_prev_reg;
    if (rx_sync_reg[2] == rx_sync_reg[1]) begin
      rx_pin_clean = rx_sync_reg[2];
    end
  end

  // receiver input routing
  always_comb begin
    rx_in = rx_pin_clean;
    if (frame_reg[B_LOOP]) begin
      rx_in = frame_reg[B_SRC] ? tx_pin : txo_reg;
    end
  end

  // receiver tick: sixteen per bit from the divider
  always_comb begin
    tick_en = (div_reg == 16'h0000);
    div_next = tick_en ? DIV_RST : div_reg - 16'h0001;
  end

  // apb decode, word index from byte address
  always_comb begin
    idx = paddr[ADDR_W+1:2];
    acc = psel && penable && !pready_reg;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    hit = (idx == IDX_MAP_CTRL) || (idx == IDX_TX_CTRL) || (idx == IDX_LINE_STAT)
      || (map_reg && (idx == IDX_ALT_STATUS || idx == IDX_ALT_IRQ_EN
      || idx == IDX_ALT_IR_CTRL))
      || (!map_reg && idx == IDX_FRAME_CTRL);
  end

  // edge, mismatch and break events
  always_comb begin
    edge_ev = (rx_prev_reg != rx_in) && (rx_in == pol_reg);
    sample_en = tick_en && (st_reg != UPL_IDLE) &&
      ((alt_ir_reg[B_MM_LO+:2] == MM_T9 && tick_reg == TICK_9) ||
       (alt_ir_reg[B_MM_LO+:2] == MM_T13 && tick_reg == TICK_13));
    mis_ev = sample_en && (rx_in != txo_reg);
    // break: rx low for ten whole bit times counted in ticks, free of tick phase
    brk_ev = alt_ir_reg[B_BKON] && brk_armed_reg && tick_en && !rx_in
      && low_cnt_reg == 8'(BRK_BITS * TICKS_PER_BIT - 1);
  end

  always_comb begin
    low_cnt_next = low_cnt_reg;
    brk_armed_next = brk_armed_reg;
    if (rx_in) begin
      low_cnt_next = 8'h00;
      brk_armed_next = 1'b1;
    end else if (tick_en && low_cnt_reg != 8'hff) begin
      low_cnt_next = low_cnt_reg + 8'h01;
      if (brk_ev) begin
        brk_armed_next = 1'b0;
      end
    end
  end

  // transmitter with parity in msb
  always_comb begin
    nbits = 4'h8;
    par_bit = (^txd_reg[6:0]) ^ frame_reg[B_ODD];
    st_next = st_reg;
    sh_next = sh_reg;
    txo_next = txo_reg;
    oe_next = oe_reg;
    tick_next = tick_reg;
    bitn_next = bitn_reg;
    txgo_next = txgo_reg;
    if (tick_en) begin
      tick_next = tick_reg + 4'h1;
    end
    case (st_reg)
      UPL_IDLE: begin
        txo_next = 1'b1;
        oe_next = 1'b1;
        if (txgo_reg && tick_en) begin
          // parity takes the place of the character's msb
          sh_next = {1'b0, frame_reg[B_PAR] ? {par_bit, txd_reg[6:0]} : txd_reg};
          st_next = UPL_START;
          txo_next = 1'b0;
          tick_next = 4'h0;
          txgo_next = 1'b0;
        end
      end
      UPL_START: begin
        if (tick_en && tick_reg == 4'hf) begin
          st_next = UPL_DATA;
          txo_next = sh_reg[0];
          sh_next = {1'b0, sh_reg[8:1]};
          bitn_next = 4'h1;
        end
      end
      UPL_DATA: begin
        if (tick_en && tick_reg == 4'hf) begin
          if (bitn_reg == nbits) begin
            st_next = UPL_STOP;
            txo_next = 1'b1;
          end else begin
            txo_next = sh_reg[0];
            sh_next = {1'b0, sh_reg[8:1]};
            bitn_next = bitn_reg + 4'h1;
          end
        end
      end
      UPL_STOP: begin
        if (tick_en && tick_reg == 4'hf) begin
          st_next = UPL_IDLE;
        end
      end
      default: begin
        st_next = UPL_IDLE;
      end
    endcase
    if (frame_reg[B_LOOP] && !frame_reg[B_SRC]) begin
      oe_next = 1'b1;
    end
    if (wr && idx == IDX_TX_CTRL && pwdata[B_TXGO]) begin
      txgo_next = 1'b1;
    end
  end

  // register file
  always_comb begin
    alt_stat_next = alt_stat_reg;
    alt_ien_next = alt_ien_reg;
    alt_ir_next = alt_ir_reg;
    frame_next = frame_reg;
    map_next = map_reg;
    pol_next = pol_reg;
    txd_next = txd_reg;
    prdata_next = prdata_reg;
    pready_next = acc;
    pslverr_next = acc && !hit;
    if (wr && map_reg && idx == IDX_ALT_STATUS) begin
      alt_stat_next[B_EDGE] = alt_stat_reg[B_EDGE] & ~pwdata[B_EDGE];
      alt_stat_next[B_MIS] = alt_stat_reg[B_MIS] & ~pwdata[B_MIS];
      alt_stat_next[B_BRK] = alt_stat_reg[B_BRK] & ~pwdata[B_BRK];
    end
    if (wr && map_reg && idx == IDX_ALT_IRQ_EN) begin
      alt_ien_next = pwdata[7:0] & 8'h83;
    end
    if (wr && map_reg && idx == IDX_ALT_IR_CTRL) begin
      alt_ir_next = pwdata[7:0] & 8'he7;
    end
    if (wr && !map_reg && idx == IDX_FRAME_CTRL) begin
      frame_next = pwdata[7:0] & 8'ha3;
    end
    if (wr && idx == IDX_MAP_CTRL) begin
      map_next = pwdata[B_MAP];
      pol_next = pwdata[B_POL];
    end
    if (wr && idx == IDX_TX_CTRL && pwdata[B_TXGO]) begin
      txd_next = pwdata[15:8];
    end
    // set wins over clear
    if (edge_ev) begin
      alt_stat_next[B_EDGE] = 1'b1;
    end
    if (mis_ev) begin
      alt_stat_next[B_MIS] = 1'b1;
      alt_stat_next[B_MISV] = rx_in;
    end
    if (brk_ev) begin
      alt_stat_next[B_BRK] = 1'b1;
    end
    if (rd) begin
      prdata_next = 32'h0000_0000;
      if (map_reg && idx == IDX_ALT_STATUS) begin
        prdata_next[7:0] = alt_stat_reg;
      end else if (map_reg && idx == IDX_ALT_IRQ_EN) begin
        prdata_next[7:0] = alt_ien_reg;
      end else if (map_reg && idx == IDX_ALT_IR_CTRL) begin
        prdata_next[7:0] = alt_ir_reg;
      end else if (!map_reg && idx == IDX_FRAME_CTRL) begin
        prdata_next[7:0] = frame_reg;
      end else if (idx == IDX_MAP_CTRL) begin
        prdata_next[1:0] = {pol_reg, map_reg};
      end else if (idx == IDX_TX_CTRL) begin
        prdata_next[15:0] = {txd_reg, 7'h00, txgo_reg};
      end else if (idx == IDX_LINE_STAT) begin
        prdata_next[3:0] = {rx_in, txo_reg, st_reg};
      end
    end
    irq_next = |(alt_stat_next & alt_ien_next & 8'h83);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alt_stat_reg <= REG_RST;
      alt_ien_reg <= REG_RST;
      alt_ir_reg <= REG_RST;
      frame_reg <= REG_RST;
      map_reg <= 1'b0;
      pol_reg <= 1'b0;
      txd_reg <= REG_RST;
      txgo_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      div_reg <= DIV_RST;
      tick_reg <= 4'h0;
      bitn_reg <= 4'h0;
      st_reg <= UPL_IDLE;
      sh_reg <= 9'h000;
      txo_reg <= 1'b1;
      oe_reg <= 1'b0;
      irq_reg <= 1'b0;
      ir_reg <= 1'b0;
      low_cnt_reg <= 8'h00;
      brk_armed_reg <= 1'b0;
    end else begin
      alt_stat_reg <= alt_stat_next;
      alt_ien_reg <= alt_ien_next;
      alt_ir_reg <= alt_ir_next;
      frame_reg <= frame_next;
      map_reg <= map_next;
      pol_reg <= pol_next;
      txd_reg <= txd_next;
      txgo_reg <= txgo_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      rx_prev_reg <= rx_in;
      div_reg <= div_next;
      tick_reg <= tick_next;
      bitn_reg <= bitn_next;
      st_reg <= st_next;
      sh_reg <= sh_next;
      txo_reg <= txo_next;
      oe_reg <= oe_next;
      irq_reg <= irq_next;
      ir_reg <= alt_ir_next[B_IR];
      low_cnt_reg <= low_cnt_next;
      brk_armed_reg <= brk_armed_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_pin = txo_reg;
  assign tx_pin_oe = oe_reg;
  assign ir_on = ir_reg;
  assign irq = irq_reg;

  property p_edge_set;
    @(posedge clk_sys) disable iff (rst) edge_ev |=> alt_stat_reg[B_EDGE];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

  property p_edge_hold;
    @(posedge clk_sys) disable iff (rst)
      alt_stat_reg[B_EDGE] && !(wr && map_reg && idx == IDX_ALT_STATUS && pwdata[B_EDGE])
      |=> alt_stat_reg[B_EDGE];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");

  property p_mis_set;
    @(posedge clk_sys) disable iff (rst) mis_ev |=> alt_stat_reg[B_MIS]
      && alt_stat_reg[B_MISV] == $past(rx_in);
  endproperty
  a_mis_set: assert property (p_mis_set) else $error("mismatch not recorded");

  property p_mis_off;
    @(posedge clk_sys) disable iff (rst)
      alt_ir_reg[B_MM_LO+:2] == MM_OFF |-> !mis_ev;
  endproperty
  a_mis_off: assert property (p_mis_off) else $error("mismatch while off");

  property p_brk_off;
    @(posedge clk_sys) disable iff (rst) !alt_ir_reg[B_BKON] |-> !brk_ev;
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("break while off");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
      irq == |(alt_stat_reg & alt_ien_reg & 8'h83);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_loop;
    @(posedge clk_sys) disable iff (rst)
      frame_reg[B_LOOP] && !frame_reg[B_SRC] |-> rx_in == txo_reg;
  endproperty
  a_loop: assert property (p_loop) else $error("loop routing wrong");

  property p_map;
    @(posedge clk_sys) disable iff (rst)
      wr && !map_reg && idx == IDX_ALT_IRQ_EN |=> $stable(alt_ien_reg);
  endproperty
  a_map: assert property (p_map) else $error("alt reg written in normal map");
endmodule

/* verification/upl_remote_node.sv */
`timescale 1ns/1ps
module upl_remote_node (
  input wire logic clk_sys,
  input wire logic tx_pin,
  input wire logic tx_pin_oe,
  input wire logic [1:0] mode,
  output logic rx_pin
);
  logic [19:0] dly_reg;
  always_ff @(posedge clk_sys) begin
    dly_reg <= {dly_reg[18:0], tx_pin};
  end
  // 0 prompt echo, 1 stuck low, 2 slow echo, 3 stuck high; in mode 0 a released line sits at pull-up
  always_comb begin
    case (mode)
      2'h0: rx_pin = tx_pin_oe ? tx_pin : 1'b1;
      2'h1: rx_pin = 1'b0;
      2'h2: rx_pin = dly_reg[19];
      default: rx_pin = 1'b1;
    endcase
  end
endmodule

/* verification/uart_parity_loop_error_detect_tb.sv */
`timescale 1ns/1ps
module uart_parity_loop_error_detect_tb;
  import upl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W+1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_pin, tx_pin, tx_pin_oe, ir_on, irq;
  logic [1:0] node_mode = 2'h0;
  logic [31:0] rd, v, seed = 32'h0000c105;
  logic [7:0] d;
  logic err;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int i, e;
  int pm[5] = '{0, 2, 1, 1, 3};
  int mm[5] = '{1, 2, 1, 0, 1};
  logic [31:0] lp[3] = '{32'h00, 32'h80, 32'ha0};

  always #25 clk_sys = ~clk_sys;

  upl_core upl_core_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe),
    .ir_on(ir_on), .irq(irq));
  upl_remote_node upl_remote_node_i (.clk_sys(clk_sys), .tx_pin(tx_pin),
    .tx_pin_oe(tx_pin_oe), .mode(node_mode), .rx_pin(rx_pin));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    // pready is read at the rising edge itself, before the design updates it
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask

  task rdx(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // wait for the start to be taken, then for the line to go idle
  task wait_tx();
    int k;
    k = 0;
    do begin
      apb(1'b0, IDX_TX_CTRL, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 1000);
    do begin
      apb(1'b0, IDX_LINE_STAT, 32'h0);
      k++;
    end while (rd[1:0] !== 2'h0 && k < 1000);
    if (k >= 1000) begin
      bad_count++;
      wrap_up();
    end
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rdx(IDX_FRAME_CTRL, 32'h0);
    apb(1'b0, IDX_ALT_STATUS, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h03f, 32'h0);
    chk(32'(err), 32'h1);
    v = xs();
    apb(1'b1, IDX_FRAME_CTRL, v);
    rdx(IDX_FRAME_CTRL, v & 32'ha3);
    // transmitter and receiver are always on here, so loop modes are usable at once
    node_mode <= 2'h1;
    for (i = 0; i < 3; i++) begin
      apb(1'b1, IDX_FRAME_CTRL, lp[i]);
      repeat (4) @(posedge clk_sys);
      apb(1'b0, IDX_LINE_STAT, 32'h0);
      chk(rd & 32'h8, (i != 0) ? 32'h8 : 32'h0);
    end
    node_mode <= 2'h0;
    for (i = 0; i < 3; i++) begin
      d = xs();
      apb(1'b1, IDX_FRAME_CTRL, (i == 2) ? 32'h0 : (32'h2 | i));
      apb(1'b1, IDX_TX_CTRL, {16'h0, d, 8'h01});
      e = 0;
      while (tx_pin !== 1'b0 && e < 100) begin
        @(negedge clk_sys);
        e++;
      end
      repeat (8 * 144 + 72) @(posedge clk_sys);
      // slot of the character's msb: parity when enabled, plain data bit otherwise
      chk(32'(tx_pin), (i == 2) ? 32'(d[7]) : 32'((^d[6:0]) ^ i[0]));
      wait_tx();
    end
    apb(1'b1, IDX_MAP_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      v = (i << 5) | ((i & 1) << 7);
      apb(1'b1, IDX_ALT_IR_CTRL, v);
      rdx(IDX_ALT_IR_CTRL, v);
      chk(32'(ir_on), i & 1);
    end
    v = xs();
    apb(1'b1, IDX_ALT_IRQ_EN, v);
    rdx(IDX_ALT_IRQ_EN, v & 32'h83);
    apb(1'b1, IDX_ALT_IRQ_EN, 32'h80);
    apb(1'b1, IDX_ALT_STATUS, 32'hff);
    node_mode <= 2'h1;
    repeat (6) @(posedge clk_sys);
    rdx(IDX_ALT_STATUS, 32'h80);
    chk(32'(irq), 32'h1);
    apb(1'b1, IDX_ALT_STATUS, 32'h0);
    rdx(IDX_ALT_STATUS, 32'h80);
    apb(1'b1, IDX_ALT_STATUS, 32'h80);
    rdx(IDX_ALT_STATUS, 32'h0);
    apb(1'b1, IDX_ALT_IRQ_EN, 32'h0);
    apb(1'b1, IDX_MAP_CTRL, 32'h3);
    node_mode <= 2'h0;
    repeat (6) @(posedge clk_sys);
    rdx(IDX_ALT_STATUS, 32'h80);
    chk(32'(irq), 32'h0);
    apb(1'b1, IDX_MAP_CTRL, 32'h1);
    for (i = 0; i < 5; i++) begin
      node_mode <= pm[i][1:0];
      apb(1'b1, IDX_ALT_IRQ_EN, 32'h2);
      apb(1'b1, IDX_ALT_IR_CTRL, mm[i] << 1);
      apb(1'b1, IDX_ALT_STATUS, 32'hff);
      apb(1'b1, IDX_TX_CTRL, (pm[i] == 3) ? 32'h0001 : 32'hff01);
      wait_tx();
      e = (pm[i] == 3) ? 6 : 2;
      e = ((pm[i] == 1 || pm[i] == 3) && mm[i] != 0) ? e : 0;
      apb(1'b0, IDX_ALT_STATUS, 32'h0);
      chk(rd & 32'h6, e);
      chk(32'(irq), e != 0);
      apb(1'b1, IDX_ALT_STATUS, 32'h2);
      // level field stays; edge flag follows the echo and is not judged here
      apb(1'b0, IDX_ALT_STATUS, 32'h0);
      chk(rd & 32'h7, e & 32'h4);
    end
    node_mode <= 2'h0;
    apb(1'b1, IDX_ALT_IR_CTRL, 32'h1);
    apb(1'b1, IDX_ALT_IRQ_EN, 32'h1);
    apb(1'b1, IDX_ALT_STATUS, 32'hff);
    node_mode <= 2'h1;
    repeat (1300) @(posedge clk_sys);
    apb(1'b0, IDX_ALT_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    repeat (300) @(posedge clk_sys);
    apb(1'b0, IDX_ALT_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk(32'(irq), 32'h1);
    node_mode <= 2'h0;
    apb(1'b1, IDX_ALT_STATUS, 32'hff);
    // level field keeps the last mismatch, a high sampled while low was sent
    rdx(IDX_ALT_STATUS, 32'h4);
    wrap_up();
  end
endmodule
